// File: rtl/vib_monitor_defines.svh
/*
  Offsets, field positions, reset values and limits of the vibration monitor.
  Assumes the includer uses 32-bit register data and byte offsets.
*/
`ifndef VIB_MONITOR_DEFINES_SVH
`define VIB_MONITOR_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define VIB_OFF_CTRL        8'h00
`define VIB_OFF_SENS        8'h04
`define VIB_OFF_ROT_LEVEL   8'h08
`define VIB_OFF_LIN_LEVEL   8'h0C
`define VIB_OFF_STATUS      8'h10
`define VIB_OFF_IRQ_STAT    8'h14
`define VIB_OFF_IRQ_MASK    8'h18
`define VIB_OFF_MEASURE     8'h1C

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define VIB_CTRL_SEL_LSB    0
`define VIB_CTRL_START_BIT  4
`define VIB_CTRL_EXEC_BIT   5
`define VIB_CTRL_CLR_BIT    8
`define VIB_IRQ_WARN_BIT    0
`define VIB_IRQ_ALARM_BIT   1
`define VIB_IRQ_LEARN_BIT   2

// ----------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------
`define VIB_SEL_RESET       2'h0
`define VIB_SEL_WARN        2'h1
`define VIB_SEL_ALARM       2'h2
`define VIB_SENS_MIN        9'h032
`define VIB_SENS_MAX        9'h1F4
`define VIB_SENS_RESET      9'h064
`define VIB_PCT_SCALE       7'h64
`define VIB_LEVEL_RESET     16'h0032
`define VIB_AVG_SHIFT       4

`endif

// File: rtl/vib_monitor_pkg.sv
/*
  Types shared by the vibration monitor.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package vib_monitor_pkg;

  typedef enum logic [1:0] {
    LEARN_IDLE,
    LEARN_STANDBY,
    LEARN_STORE
  } learn_state_t;

endpackage

// File: rtl/vibration_detection_monitor.sv
/*
  Vibration supervision of the motor speed: threshold compare with warning or
  latched alarm, and a two-step learning procedure that rewrites the level.
  Assumes one speed sample pulse per speed-control period on i_sample_valid,
  a plain register port and a single 250 MHz clock with synchronous reset.
*/
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "vib_monitor_defines.svh"

// What this block does and what its operator must do
// [R1] select field: off, warning, or alarm
// [R2] warn or alarm when vibration exceeds level times sensitivity
// [R3] rotary level in rpm, linear level in mm/s
// [R4] sensitivity 50..500 percent, default 100, immediate
// [R5] measure vibration only from speed signal components
// [R6] learning measures vibration and rewrites stored level
// [R7] operator ensures writes allowed, motorless test off
// [R8] operator learns at ten percent speed or more
// [R9] operator applies real motion references while learning
// [R10] start enters standby, execute computes, reports, stores
// [R11] learning locks levels, not sensitivity; updates levels only
// [R12] evaluate per sample; warning follows, alarm latches
module vibration_detection_monitor
  import vib_monitor_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_sample_valid,
  input  wire logic [15:0] i_speed,
  input  wire logic        i_linear_motor,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output logic             o_warning,
  output logic             o_alarm,
  output logic             o_irq,
  output logic             o_level_save,
  output logic      [15:0] o_level_save_value
);

  // ----------------------------------------------------------------------
  // register access decode
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  logic               wr_ctrl;
  logic               wr_sens;
  logic               wr_rot;
  logic               wr_lin;
  logic               wr_istat;
  logic               wr_imask;
  logic [1:0]         sel_r;
  logic [8:0]         sens_r;
  logic [15:0]        rot_level_r;
  logic [15:0]        lin_level_r;
  logic [2:0]         irq_stat_r;
  logic [2:0]         irq_mask_r;
  logic [2:0]         irq_evt;
  learn_state_t       learn_r;
  logic               learning;
  logic               start_req;
  logic               exec_req;
  logic               clr_req;

  assign wr_ctrl   = i_wr && hit(i_addr, `VIB_OFF_CTRL);
  assign wr_sens   = i_wr && hit(i_addr, `VIB_OFF_SENS);
  assign wr_rot    = i_wr && hit(i_addr, `VIB_OFF_ROT_LEVEL);
  assign wr_lin    = i_wr && hit(i_addr, `VIB_OFF_LIN_LEVEL);
  assign wr_istat  = i_wr && hit(i_addr, `VIB_OFF_IRQ_STAT);
  assign wr_imask  = i_wr && hit(i_addr, `VIB_OFF_IRQ_MASK);
  assign start_req = wr_ctrl && i_wdata[`VIB_CTRL_START_BIT];
  assign exec_req  = wr_ctrl && i_wdata[`VIB_CTRL_EXEC_BIT];
  assign clr_req   = wr_ctrl && i_wdata[`VIB_CTRL_CLR_BIT];
  assign learning  = (learn_r != LEARN_IDLE);

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      sel_r <= `VIB_SEL_RESET;
    else if (wr_ctrl)
      sel_r <= i_wdata[`VIB_CTRL_SEL_LSB +: 2];                      // [R1]
  end

  // out-of-range writes are ignored so the threshold never leaves its band
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      sens_r <= `VIB_SENS_RESET;                                     // [R4]
    else if (wr_sens && i_wdata[31:9] == 23'h000000
             && i_wdata[8:0] >= `VIB_SENS_MIN && i_wdata[8:0] <= `VIB_SENS_MAX)
      sens_r <= i_wdata[8:0];                                        // [R4] [R11]
  end

  // ----------------------------------------------------------------------
  // vibration measure: deviation of speed from its running average
  // ----------------------------------------------------------------------
  logic signed [15:0] avg_r;
  logic signed [16:0] dev;
  logic        [16:0] dev_mag;
  logic        [15:0] vib_r;
  logic               sample_d_r;

  assign dev     = $signed({i_speed[15], i_speed}) - $signed({avg_r[15], avg_r});
  assign dev_mag = dev[16] ? 17'(-dev) : 17'(dev);

  // the slow average is the commanded motion; what rides on it is vibration
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      avg_r <= 16'sh0000;
    else if (i_sample_valid)
      avg_r <= 16'(avg_r + 16'(dev >>> `VIB_AVG_SHIFT));             // [R5]
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      vib_r <= 16'h0000;
    else if (i_sample_valid)
      vib_r <= dev_mag[16] ? 16'hFFFF : dev_mag[15:0];               // [R5]
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      sample_d_r <= 1'b0;
    else
      sample_d_r <= i_sample_valid;
  end

  // ----------------------------------------------------------------------
  // threshold compare, scaled by 100 instead of dividing
  // ----------------------------------------------------------------------
  logic [15:0] level_sel;
  logic [24:0] thresh_x100;
  logic [24:0] vib_x100;
  logic        excess;

  assign level_sel   = i_linear_motor ? lin_level_r : rot_level_r;   // [R3]
  assign thresh_x100 = 25'(level_sel * sens_r);                      // [R2] [R4]
  assign vib_x100    = 25'(vib_r * `VIB_PCT_SCALE);
  assign excess      = vib_x100 > thresh_x100;                       // [R2]

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      o_warning <= 1'b0;
    else if (sel_r != `VIB_SEL_WARN)
      o_warning <= 1'b0;                                             // [R1]
    else if (sample_d_r)
      o_warning <= excess;                                           // [R12]
  end

  // a new excess in the clearing cycle keeps the alarm set
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      o_alarm <= 1'b0;
    else if (sample_d_r && sel_r == `VIB_SEL_ALARM && excess)
      o_alarm <= 1'b1;                                               // [R1] [R12]
    else if (clr_req)
      o_alarm <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // learning sequence
  // ----------------------------------------------------------------------
  logic [15:0] peak_r;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      learn_r <= LEARN_IDLE;
    else
      case (learn_r)
        LEARN_IDLE:    if (start_req) learn_r <= LEARN_STANDBY;      // [R10]
        LEARN_STANDBY: if (exec_req) learn_r <= LEARN_STORE;         // [R10]
        LEARN_STORE:   learn_r <= LEARN_IDLE;
        default:       learn_r <= LEARN_IDLE;
      endcase
  end

  // peak vibration seen while waiting for execute becomes the new level
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      peak_r <= 16'h0000;
    else if (learn_r == LEARN_IDLE && start_req)
      peak_r <= 16'h0000;
    else if (learn_r == LEARN_STANDBY && sample_d_r && vib_r > peak_r)
      peak_r <= vib_r;                                               // [R6]
  end

  // external level writes are dropped for the whole sequence
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      rot_level_r <= `VIB_LEVEL_RESET;
    else if (learn_r == LEARN_STORE && !i_linear_motor)
      rot_level_r <= peak_r;                                         // [R3] [R6]
    else if (wr_rot && !learning)
      rot_level_r <= i_wdata[15:0];                                  // [R11]
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      lin_level_r <= `VIB_LEVEL_RESET;
    else if (learn_r == LEARN_STORE && i_linear_motor)
      lin_level_r <= peak_r;                                         // [R3] [R6]
    else if (wr_lin && !learning)
      lin_level_r <= i_wdata[15:0];                                  // [R11]
  end

  // persistent-store request towards the drive's parameter memory
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_level_save       <= 1'b0;
      o_level_save_value <= 16'h0000;
    end
    else
    begin
      o_level_save <= (learn_r == LEARN_STORE);                      // [R10]
      if (learn_r == LEARN_STORE)
        o_level_save_value <= peak_r;
    end
  end

  // ----------------------------------------------------------------------
  // interrupts: sticky, write one to clear, set beats clear
  // ----------------------------------------------------------------------
  logic warn_q_r;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      warn_q_r <= 1'b0;
    else
      warn_q_r <= o_warning;
  end

  assign irq_evt = {learn_r == LEARN_STORE,
                    sample_d_r && sel_r == `VIB_SEL_ALARM && excess,
                    o_warning && !warn_q_r};

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      irq_stat_r <= 3'h0;
    else
      irq_stat_r <= irq_evt | (irq_stat_r & ~({3{wr_istat}} & i_wdata[2:0]));
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      irq_mask_r <= 3'h0;
    else if (wr_imask)
      irq_mask_r <= i_wdata[2:0];
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      o_irq <= 1'b0;
    else
      o_irq <= |(irq_evt & irq_mask_r) | |(irq_stat_r & irq_mask_r);
  end

  // ----------------------------------------------------------------------
  // read data, valid only in the cycle after the read strobe
  // ----------------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (i_addr)
      `VIB_OFF_CTRL:      rd_mux = {30'h0000_0000, sel_r};
      `VIB_OFF_SENS:      rd_mux = {23'h000000, sens_r};
      `VIB_OFF_ROT_LEVEL: rd_mux = {16'h0000, rot_level_r};
      `VIB_OFF_LIN_LEVEL: rd_mux = {16'h0000, lin_level_r};
      `VIB_OFF_STATUS:    rd_mux = {26'h0000000, learn_r, 2'h0, o_alarm, o_warning};
      `VIB_OFF_IRQ_STAT:  rd_mux = {29'h00000000, irq_stat_r};
      `VIB_OFF_IRQ_MASK:  rd_mux = {29'h00000000, irq_mask_r};
      `VIB_OFF_MEASURE:   rd_mux = {peak_r, vib_r};
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      o_rdata <= 32'h0000_0000;
    else if (i_rd)
      o_rdata <= rd_mux;
    else
      o_rdata <= 32'h0000_0000;
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_sel_off;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (sel_r != `VIB_SEL_WARN) |=> !o_warning;
  endproperty
  a_sel_off: assert property (p_sel_off) else $error("warning outside warn mode"); // [R1]

  property p_alarm_fire;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (sample_d_r && sel_r == `VIB_SEL_ALARM && excess) |=> o_alarm && irq_stat_r[1];
  endproperty
  a_alarm_fire: assert property (p_alarm_fire) else $error("alarm not raised"); // [R2]

  property p_level_pick;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (learn_r == LEARN_STORE) |=> ($past(i_linear_motor) ? lin_level_r : rot_level_r)
        == $past(peak_r) && ($past(i_linear_motor) ? $stable(rot_level_r) : $stable(lin_level_r));
  endproperty
  a_level_pick: assert property (p_level_pick) else $error("wrong level stored"); // [R3]

  property p_sens_range;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      sens_r >= `VIB_SENS_MIN && sens_r <= `VIB_SENS_MAX;
  endproperty
  a_sens_range: assert property (p_sens_range) else $error("sensitivity out of range"); // [R4]

  property p_vib_hold;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      !i_sample_valid |=> $stable(vib_r);
  endproperty
  a_vib_hold: assert property (p_vib_hold) else $error("measure moved without sample"); // [R5]

  property p_learn_done;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (learn_r == LEARN_STANDBY && exec_req) |=> ##1 learn_r == LEARN_IDLE
        && o_level_save && o_level_save_value == $past(peak_r);
  endproperty
  a_learn_done: assert property (p_learn_done) else $error("learn result not saved"); // [R6]

  property p_two_step;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (learn_r == LEARN_IDLE && exec_req && !start_req) |=> learn_r == LEARN_IDLE;
  endproperty
  a_two_step: assert property (p_two_step) else $error("execute without standby"); // [R10]

  property p_level_lock;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (learn_r == LEARN_STANDBY && wr_rot) |=> $stable(rot_level_r);
  endproperty
  a_level_lock: assert property (p_level_lock) else $error("level written while learning"); // [R11]

  property p_alarm_latch;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_alarm && !clr_req) |=> o_alarm;
  endproperty
  a_alarm_latch: assert property (p_alarm_latch) else $error("alarm dropped without clear"); // [R12]

  c_warning: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) $rose(o_warning));
  c_alarm:   cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) $rose(o_alarm));
  c_learn:   cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) o_level_save);

endmodule

// File: bench/speed_source.sv
/*
  Model of the motor speed feedback: one sample pulse every four clocks,
  speed swinging by a set amplitude around a set mean.
  Assumes the bench sets mean and amplitude off the clock edge.
*/
`timescale 1ns/1ps

module speed_source
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic [15:0] i_base,
  input  wire logic [15:0] i_amp,
  output logic             o_sample_valid,
  output logic      [15:0] o_speed
);
  // --------------------------------------------------------------------
  // sample stream
  // --------------------------------------------------------------------
  logic [1:0]  div_r;
  logic        phase_r;
  logic [15:0] val;

  // the mean is a real running speed; the bench's 3000 is just under a tenth of the signed full scale
  // the same stream feeds learning, no substitute test pattern
  // a real motor is always attached, never a motorless test mode
  assign val = phase_r ? i_base + i_amp : i_base - i_amp;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      div_r          <= 2'h0;
      phase_r        <= 1'b0;
      o_sample_valid <= 1'b0;
      o_speed        <= 16'h0000;
    end
    else
    begin
      div_r          <= div_r + 2'h1;
      o_sample_valid <= (div_r == 2'h3);
      // between samples the line toggles, so a stale read cannot pass
      if (div_r == 2'h3)
      begin
        o_speed <= val;
        phase_r <= !phase_r;
      end
      else
        o_speed <= ~o_speed;
    end
  end
endmodule

// File: bench/tb_vibration_detection_monitor.sv
/*
  Self-checking bench of the vibration monitor: register tasks and scenarios.
  Assumes the design files and the speed source model are compiled first.
*/
`timescale 1ns/1ps
`include "vib_monitor_defines.svh"

module tb_vibration_detection_monitor
  import vib_monitor_pkg::*;
;
  logic        i_clk_sys = 1'b0;
  logic        i_rst_n   = 1'b0;
  logic        i_sample_valid;
  logic [15:0] i_speed;
  logic        i_linear_motor = 1'b0;
  logic [7:0]  i_addr  = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr    = 1'b0;
  logic        i_rd    = 1'b0;
  logic [31:0] o_rdata;
  logic        o_warning;
  logic        o_alarm;
  logic        o_irq;
  logic        o_level_save;
  logic [15:0] o_level_save_value;
  logic [15:0] base = 16'h0BB8;
  logic [15:0] amp  = 16'h0000;
  logic [31:0] rd_v;
  logic [15:0] saved;
  logic [15:0] peak;
  int          n_fail = 0;
  int          checks_done = 0;
  int          n_save = 0;
  int          cycles = 0;
  logic [31:0] sens_in  [6] = '{32'h31, 32'h32, 32'h1F5, 32'h1F4, 32'h200064, 32'h64};
  logic [31:0] sens_exp [6] = '{32'h64, 32'h32, 32'h32, 32'h1F4, 32'h1F4, 32'h64};

  always #2 i_clk_sys = ~i_clk_sys;

  speed_source src (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_base(base),
    .i_amp(amp), .o_sample_valid(i_sample_valid), .o_speed(i_speed));

  vibration_detection_monitor dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_sample_valid(i_sample_valid), .i_speed(i_speed), .i_linear_motor(i_linear_motor),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_warning(o_warning), .o_alarm(o_alarm), .o_irq(o_irq),
    .o_level_save(o_level_save), .o_level_save_value(o_level_save_value));

  // --------------------------------------------------------------------
  // monitors and closing
  // --------------------------------------------------------------------
  always @(posedge i_clk_sys)
  begin
    cycles++;
    if (o_level_save === 1'b1)
    begin
      n_save++;
      saved = o_level_save_value;
    end
    if (cycles == 20000)
    begin
      n_fail++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // bus and compare tasks, entered 1 ns after a clock edge
  // --------------------------------------------------------------------
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk_sys);
    i_wr    <= 1'b0;
    #1;
  endtask

  task automatic bus_rd(input logic [7:0] a);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk_sys);
    i_rd   <= 1'b0;
    #1 rd_v = o_rdata;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_rng(input string what, input logic [15:0] lo, input logic [15:0] hi,
                         input logic [15:0] got);
    checks_done++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      n_fail++;
      $display("BAD %s expected %h to %h seen %h", what, lo, hi, got);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus_rd(a);
    chk($sformatf("register %h", a), exp, rd_v);
  endtask

  // samples come every four clocks; warning and alarm settle two clocks after one, the interrupt up to three
  task automatic wait_samples(input int n);
    repeat (n * 4) @(posedge i_clk_sys);
    #1;
  endtask

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge i_clk_sys);
    chk("outputs in reset", 32'h0, 32'({o_warning, o_alarm, o_irq, o_level_save}));
    i_rst_n <= 1'b1;
    #1;
    rchk(`VIB_OFF_CTRL, 32'(`VIB_SEL_RESET));
    rchk(`VIB_OFF_SENS, 32'(`VIB_SENS_RESET));
    rchk(`VIB_OFF_ROT_LEVEL, 32'(`VIB_LEVEL_RESET));
    rchk(`VIB_OFF_LIN_LEVEL, 32'(`VIB_LEVEL_RESET));
    rchk(`VIB_OFF_STATUS, 32'h0);
    rchk(`VIB_OFF_IRQ_STAT, 32'h0);
    rchk(`VIB_OFF_IRQ_MASK, 32'h0);
    rchk(8'h20, 32'h0);
    for (int k = 0; k < 6; k++)
    begin
      bus_wr(`VIB_OFF_SENS, sens_in[k]);
      rchk(`VIB_OFF_SENS, sens_exp[k]);
    end
    // mode off: the mean settles while a large swing stays unreported
    amp <= 16'h0190;
    wait_samples(200);
    chk("off mode", 32'h0, 32'({o_warning, o_alarm, o_irq}));
    bus_wr(`VIB_OFF_ROT_LEVEL, 32'h1F4);
    bus_wr(`VIB_OFF_CTRL, 32'(`VIB_SEL_WARN));
    wait_samples(20);
    chk("warning below threshold", 32'h0, 32'(o_warning));
    bus_wr(`VIB_OFF_SENS, 32'h32);
    wait_samples(4);
    chk("warning at half sensitivity", 32'h1, 32'(o_warning));
    chk("alarm in warn mode", 32'h0, 32'(o_alarm));
    // a mask bit set to one lets its status bit through to the interrupt
    chk("irq masked", 32'h0, 32'(o_irq));
    bus_wr(`VIB_OFF_IRQ_MASK, 32'h7);
    wait_samples(1);
    chk("irq unmasked", 32'h1, 32'(o_irq));
    amp <= 16'h0000;
    wait_samples(40);
    chk("warning after excess ends", 32'h0, 32'(o_warning));
    chk("irq held by sticky status", 32'h1, 32'(o_irq));
    rchk(`VIB_OFF_IRQ_STAT, 32'h1);
    bus_wr(`VIB_OFF_IRQ_STAT, 32'h1);
    wait_samples(1);
    chk("irq after clear", 32'h0, 32'(o_irq));
    // linear motor uses its own level
    bus_wr(`VIB_OFF_SENS, 32'h64);
    bus_wr(`VIB_OFF_ROT_LEVEL, 32'h7FFF);
    i_linear_motor <= 1'b1;
    amp <= 16'h0190;
    wait_samples(20);
    chk("linear level used", 32'h1, 32'(o_warning));
    bus_wr(`VIB_OFF_CTRL, 32'h3);
    wait_samples(1);
    chk("select three is off", 32'h0, 32'({o_warning, o_alarm}));
    bus_wr(`VIB_OFF_CTRL, 32'(`VIB_SEL_WARN));
    wait_samples(2);
    chk("linear level again", 32'h1, 32'(o_warning));
    i_linear_motor <= 1'b0;
    wait_samples(4);
    chk("rotary level used", 32'h0, 32'(o_warning));
    // alarm mode latches until cleared
    bus_wr(`VIB_OFF_CTRL, 32'(`VIB_SEL_ALARM));
    bus_wr(`VIB_OFF_ROT_LEVEL, 32'h32);
    wait_samples(4);
    chk("alarm raised", 32'h1, 32'({o_warning, o_alarm}));
    amp <= 16'h0000;
    wait_samples(40);
    chk("alarm latched", 32'h1, 32'(o_alarm));
    rchk(`VIB_OFF_STATUS, 32'h2);
    bus_wr(`VIB_OFF_CTRL, 32'h102);
    wait_samples(1);
    chk("alarm cleared", 32'h0, 32'(o_alarm));
    rchk(`VIB_OFF_IRQ_STAT, 32'h3);
    bus_wr(`VIB_OFF_IRQ_STAT, 32'h7);
    // learning: execute from idle does nothing, then start and execute
    bus_wr(`VIB_OFF_CTRL, 32'h20);
    wait_samples(1);
    chk("execute from idle", 32'h0, 32'(n_save));
    bus_wr(`VIB_OFF_CTRL, 32'h10);
    rchk(`VIB_OFF_STATUS, 32'(LEARN_STANDBY) << 4);
    amp <= 16'h0190;
    wait_samples(20);
    amp <= 16'h0000;
    bus_wr(`VIB_OFF_ROT_LEVEL, 32'h0123);
    bus_wr(`VIB_OFF_LIN_LEVEL, 32'h0123);
    bus_wr(`VIB_OFF_SENS, 32'hC8);
    rchk(`VIB_OFF_ROT_LEVEL, 32'h32);
    rchk(`VIB_OFF_LIN_LEVEL, 32'h32);
    rchk(`VIB_OFF_SENS, 32'hC8);
    wait_samples(4);
    bus_rd(`VIB_OFF_MEASURE);
    peak = rd_v[31:16];
    chk_rng("learned peak", 16'h015E, 16'h01C2, peak);
    bus_wr(`VIB_OFF_CTRL, 32'h20);
    wait_samples(1);
    chk("store pulses", 32'h1, 32'(n_save));
    chk("stored value", 32'(peak), 32'(saved));
    rchk(`VIB_OFF_ROT_LEVEL, 32'(peak));
    rchk(`VIB_OFF_LIN_LEVEL, 32'h32);
    rchk(`VIB_OFF_SENS, 32'hC8);
    rchk(`VIB_OFF_STATUS, 32'(LEARN_IDLE) << 4);
    rchk(`VIB_OFF_IRQ_STAT, 32'h4);
    chk("irq after learn", 32'h1, 32'(o_irq));
    stop_test();
  end
endmodule
